/* inc/msmt_pkg.sv */
// ****************************************************************
// speed measurement timer constants
// ****************************************************************
package msmt_pkg;

  // ****************************************************************
  // register byte offsets on the apb
  // ****************************************************************
  localparam logic [7:0] OFF_CNT_HI   = 8'h00; // speed_counter_high
  localparam logic [7:0] OFF_CNT_LO   = 8'h04; // speed_counter_low
  localparam logic [7:0] OFF_CAP_HI   = 8'h08; // capture_high_byte
  localparam logic [7:0] OFF_CAP_LO   = 8'h0C; // capture_low_byte
  localparam logic [7:0] OFF_COMM_CMP = 8'h10; // commutation_compare
  localparam logic [7:0] OFF_SPD_CMP  = 8'h14; // speed_error_compare
  localparam logic [7:0] OFF_CTRL     = 8'h18; // control_register_a
  localparam logic [7:0] OFF_PRESC    = 8'h1C; // prescaler_register
  localparam logic [7:0] OFF_FLAGS    = 8'h20; // irq_flag_register
  localparam logic [7:0] OFF_MASK     = 8'h24; // irq mask register

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTRL_CKE_BIT  = 0;   // peripheral clock enable
  localparam int CTRL_SNS_LSB  = 1;   // sensor select, two bits
  localparam int CTRL_ECS_BIT  = 3;   // encoder_capture_select
  localparam int CTRL_DBG_BIT  = 4;   // debug capture pulse enable
  localparam logic [1:0] SNS_POSITION = 2'h0; // sensor/sensorless modes
  localparam logic [1:0] SNS_TACHO    = 2'h1;
  localparam logic [1:0] SNS_HALL     = 2'h2;
  localparam logic [1:0] SNS_ENCODER  = 2'h3;

  // ****************************************************************
  // flag and mask bit positions
  // ****************************************************************
  localparam int FLG_CAPT_BIT = 0;   // commutation/capture flag
  localparam int FLG_UP_BIT   = 1;   // prescaler_up_flag
  localparam int FLG_DOWN_BIT = 2;   // prescaler_down_flag
  localparam int FLG_SPD_BIT  = 3;   // speed error flag
  localparam int FLG_EMG_BIT  = 4;   // emergency halt flag
  localparam int MSK_CAPT_BIT = 0;   // capture mask
  localparam int MSK_PCHG_BIT = 1;   // prescaler_change_mask
  localparam int MSK_SPD_BIT  = 2;   // speed error mask

  // ****************************************************************
  // reset values and counter thresholds
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [3:0]  RST_PRESC    = 4'h0;
  localparam logic [15:0] CNT_FULL     = 16'hFFFF;
  localparam logic [15:0] CNT_LOW_LIM  = 16'h5500;
  localparam logic [7:0]  SPD_LOW_BYTE = 8'hFF;
  localparam logic [3:0]  PRESC_MAX    = 4'hF;
  localparam logic [3:0]  PRESC_MIN    = 4'h0;

  // ****************************************************************
  // clock rates; counter source tick by phase accumulation
  // ****************************************************************
  localparam int CORE_MHZ   = 40;
  localparam int PERIPH_MHZ = 16;
  localparam logic [5:0] PHASE_STEP = 6'(PERIPH_MHZ);
  localparam logic [5:0] PHASE_MOD  = 6'(CORE_MHZ);

endpackage : msmt_pkg

/* rtl/msmt_timer.sv */
`timescale 1ns/1ps
// Behaviour
// [R1] tacho active edge captures the counter
// [R2] encoder manual: high byte read captures
// [R3] encoder automatic: clock tick captures
// [R4] source is 16 MHz or encoder clock
// [R5] at FFFFh: prescaler up, shift right, flag
// [R6] capture below 5500h: prescaler down, flag
// [R7] prescaler zero: no decrement, no flag
// [R8] prescaler 15 at FFFFh: counter holds
// [R9] counter bytes update by hardware
// [R10] capture reuses commutation flag and mask
// [R11] prescaler change raises up/down flag
// [R12] speed error on counter equals compare:FF
// [R13] speed error shares emergency halt line
// [R14] three independent interrupt masks
// [R15] software sets counter up with clock off
// [R16] low byte unused in position modes
// [R17] debug pulse on capture events
// [R18] counter bytes readable, reset to zero
// [R19] capture registers hold counter bytes
// [R20] speed compare used, commutation unused
// [R21] capture copies then clears counter
// [R22] high capture read locks low byte
// [R23] each prescaler step halves counter rate
module msmt_timer
(
  // clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        SRST_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // sensor pins and time base
  input  wire logic        TACHO_IN,
  input  wire logic        ENC_CLK_IN,
  input  wire logic        EMERG_HALT_IN,
  input  wire logic        RTC_TICK_IN,
  // interrupt lines and debug
  output logic             CAPT_IRQ_OUT,
  output logic             PRESC_IRQ_OUT,
  output logic             HALT_IRQ_OUT,
  output logic             DBG_CAPT_OUT
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // address match, used by read mux and all write paths
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // divider hit: low s bits of the divider all ones
  function automatic logic presc_hit(input logic [14:0] d,
                                     input logic [3:0]  s);
    logic [15:0] m;
    m = (16'h0001 << s) - 16'h0001;
    presc_hit = ((d & m[14:0]) == m[14:0]);
  endfunction : presc_hit

  // ****************************************************************
  // state and registers
  // ****************************************************************
  logic [2:0]  pin_s1_ff;       // first sync stage, pins
  logic [2:0]  pin_s2_ff;       // second sync stage
  logic [2:0]  pin_s3_ff;       // previous value for edges
  logic [5:0]  phase_ff;        // 16 MHz phase accumulator
  logic [5:0]  nxt_phase;
  logic        periph_tick;     // 16 MHz enable pulse
  logic [14:0] div_ff;          // prescaler divider
  logic [15:0] cnt_ff;          // speed counter high:low
  logic [7:0]  cap_hi_ff;       // capture_high_byte
  logic [7:0]  cap_lo_ff;       // capture_low_byte
  logic [7:0]  comm_cmp_ff;     // commutation_compare, storage only
  logic [7:0]  spd_cmp_ff;      // speed_error_compare
  logic [4:0]  ctrl_ff;         // control_register_a
  logic [3:0]  presc_ff;        // prescale_field
  logic [4:0]  flag_ff;         // irq_flag_register
  logic [2:0]  mask_ff;         // irq masks
  logic        lock_ff;         // capture low byte locked
  logic        match_ff;        // previous compare match
  logic        dbg_ff;          // debug capture pulse
  logic [31:0] rdata_ff;        // registered read data

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic        setup_rd;
  logic        acc;
  logic        acc_wr;
  logic        acc_rd;
  logic        mapped;
  logic        cke;
  logic [1:0]  sns;
  logic        speed_mode;
  logic        run;

  assign setup_rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  assign acc      = PSEL_IN & PENABLE_IN;
  assign acc_wr   = acc & PWRITE_IN;
  assign acc_rd   = acc & ~PWRITE_IN;
  assign mapped   = (PADDR_IN <= msmt_pkg::OFF_MASK) &
                    (PADDR_IN[1:0] == 2'h0);
  assign cke      = ctrl_ff[msmt_pkg::CTRL_CKE_BIT];
  assign sns      = ctrl_ff[msmt_pkg::CTRL_SNS_LSB +: 2];
  assign speed_mode = (sns != msmt_pkg::SNS_POSITION);
  assign run      = cke & speed_mode;

  // zero wait state slave; unmapped addresses answer with an error
  assign PREADY_OUT  = acc;
  assign PSLVERR_OUT = acc & ~mapped;
  assign PRDATA_OUT  = rdata_ff;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // bit 0 tacho/hall, bit 1 encoder clock, bit 2 emergency halt
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
    end
    else
    begin
      pin_s1_ff <= {EMERG_HALT_IN, ENC_CLK_IN, TACHO_IN};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // ****************************************************************
  // event decode
  // ****************************************************************
  logic tacho_rise;
  logic hall_edge;
  logic enc_rise;
  logic emerg_rise;
  logic capt_evt;
  logic capt_acc;
  logic src_tick;
  logic cnt_tick;
  logic at_full;
  logic tick_up;
  logic tick_hold;
  logic dn_ok;
  logic match;
  logic presc_wr;

  assign tacho_rise = pin_s2_ff[0] & ~pin_s3_ff[0];
  assign hall_edge  = pin_s2_ff[0] ^ pin_s3_ff[0];
  assign enc_rise   = pin_s2_ff[1] & ~pin_s3_ff[1];
  assign emerg_rise = pin_s2_ff[2] & ~pin_s3_ff[2];

  // capture source per sensor type
  always_comb
  begin
    unique case (sns)
      msmt_pkg::SNS_TACHO: capt_evt = tacho_rise;       // R1
      msmt_pkg::SNS_HALL:  capt_evt = hall_edge;
      msmt_pkg::SNS_ENCODER:
        if (ctrl_ff[msmt_pkg::CTRL_ECS_BIT])
          capt_evt = acc_rd &                           // R2
                     reg_hit(PADDR_IN, msmt_pkg::OFF_CNT_HI);
        else
          capt_evt = RTC_TICK_IN;                       // R3
      default: capt_evt = 1'b0;
    endcase
  end

  // a capture while the low byte is locked is thrown away
  assign capt_acc = run & capt_evt & ~lock_ff; // R22

  // counter source: encoder edges or the 16 MHz enable
  assign src_tick = (sns == msmt_pkg::SNS_ENCODER) ? enc_rise
                                                   : periph_tick; // R4
  assign at_full  = (cnt_ff == msmt_pkg::CNT_FULL);
  // at top prescaler and full count the counter clock stops
  assign tick_hold = at_full & (presc_ff == msmt_pkg::PRESC_MAX); // R8
  assign cnt_tick  = run & src_tick & presc_hit(div_ff, presc_ff) &
                     ~tick_hold; // R23
  assign tick_up   = cnt_tick & at_full & ~capt_acc; // R5
  assign dn_ok     = capt_acc & (cnt_ff < msmt_pkg::CNT_LOW_LIM) &
                     (presc_ff != msmt_pkg::PRESC_MIN); // R6 R7
  assign match     = run &
                     (cnt_ff == {spd_cmp_ff, msmt_pkg::SPD_LOW_BYTE}); // R12
  assign presc_wr  = acc_wr & ~cke &
                     reg_hit(PADDR_IN, msmt_pkg::OFF_PRESC);

  // ****************************************************************
  // 16 MHz enable from the 40 MHz core clock
  // ****************************************************************
  // fractional divider: average rate exact, jitter one core cycle
  always_comb
  begin
    nxt_phase   = phase_ff + msmt_pkg::PHASE_STEP;
    periph_tick = 1'b0;
    if (nxt_phase >= msmt_pkg::PHASE_MOD)
    begin
      nxt_phase   = nxt_phase - msmt_pkg::PHASE_MOD;
      periph_tick = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      phase_ff <= 6'h00;
    else
      phase_ff <= nxt_phase;
  end

  // ****************************************************************
  // prescaler divider
  // ****************************************************************
  // restarts on every counter step so each step is 2^field ticks
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN || !run)
      div_ff <= 15'h0000;
    else if (cnt_tick || capt_acc)
      div_ff <= 15'h0000; // R23
    else if (src_tick)
      div_ff <= div_ff + 15'h0001;
  end

  // ****************************************************************
  // speed counter
  // ****************************************************************
  // the counter, prescaler, capture registers and flags are changed by hardware
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      cnt_ff <= {msmt_pkg::RST_BYTE, msmt_pkg::RST_BYTE}; // R18
    else if (capt_acc)
      cnt_ff <= 16'h0000; // R21
    else if (tick_up)
      cnt_ff <= {1'b0, cnt_ff[15:1]}; // R5
    else if (cnt_tick)
      cnt_ff <= cnt_ff + 16'h0001; // R9
    else if (acc_wr && !cke)
    begin
      // writable only with the peripheral clock off
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CNT_HI))
        cnt_ff[15:8] <= PWDATA_IN[7:0]; // R15
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CNT_LO))
        cnt_ff[7:0] <= PWDATA_IN[7:0];
    end
  end

  // ****************************************************************
  // prescaler field
  // ****************************************************************
  // a capture clears the counter, so a step down needs no left shift
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      presc_ff <= msmt_pkg::RST_PRESC;
    else if (dn_ok)
      presc_ff <= presc_ff - 4'h1; // R6
    else if (tick_up && presc_ff != msmt_pkg::PRESC_MAX)
      presc_ff <= presc_ff + 4'h1; // R5
    else if (presc_wr)
      presc_ff <= PWDATA_IN[3:0];
  end

  // ****************************************************************
  // capture registers and lock
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      cap_hi_ff <= msmt_pkg::RST_BYTE;
      cap_lo_ff <= msmt_pkg::RST_BYTE;
    end
    else if (capt_acc)
    begin
      cap_hi_ff <= cnt_ff[15:8]; // R19
      cap_lo_ff <= cnt_ff[7:0]; // R21
    end
    else if (acc_wr && !cke)
    begin
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CAP_HI))
        cap_hi_ff <= PWDATA_IN[7:0];
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CAP_LO))
        cap_lo_ff <= PWDATA_IN[7:0];
    end
  end

  // high byte read locks, low byte read releases
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      lock_ff <= 1'b0;
    else if (acc_rd && reg_hit(PADDR_IN, msmt_pkg::OFF_CAP_LO))
      lock_ff <= 1'b0;
    else if (acc_rd && reg_hit(PADDR_IN, msmt_pkg::OFF_CAP_HI))
      lock_ff <= 1'b1; // R22
  end

  // ****************************************************************
  // software configuration registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      ctrl_ff     <= 5'h00;
      mask_ff     <= 3'h0;
      comm_cmp_ff <= msmt_pkg::RST_BYTE;
      spd_cmp_ff  <= msmt_pkg::RST_BYTE;
    end
    else if (acc_wr)
    begin
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CTRL))
        ctrl_ff <= PWDATA_IN[4:0];
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_MASK))
        mask_ff <= PWDATA_IN[2:0]; // R14
      // kept for software, no effect in speed mode
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_COMM_CMP))
        comm_cmp_ff <= PWDATA_IN[7:0]; // R20
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_SPD_CMP))
        spd_cmp_ff <= PWDATA_IN[7:0]; // R20
    end
  end

  // ****************************************************************
  // interrupt flags
  // ****************************************************************
  logic [4:0] flag_set;
  logic [4:0] flag_clr;

  // software write to the field counts as a change too
  always_comb
  begin
    flag_set = 5'h00;
    flag_set[msmt_pkg::FLG_CAPT_BIT] = capt_acc; // R10
    flag_set[msmt_pkg::FLG_UP_BIT]   = (tick_up &&
        presc_ff != msmt_pkg::PRESC_MAX) ||
        (presc_wr && PWDATA_IN[3:0] > presc_ff); // R11
    flag_set[msmt_pkg::FLG_DOWN_BIT] = dn_ok ||
        (presc_wr && PWDATA_IN[3:0] < presc_ff); // R7
    flag_set[msmt_pkg::FLG_SPD_BIT]  = match & ~match_ff; // R12
    flag_set[msmt_pkg::FLG_EMG_BIT]  = emerg_rise;
    flag_clr = (acc_wr && reg_hit(PADDR_IN, msmt_pkg::OFF_FLAGS)) ?
               PWDATA_IN[4:0] : 5'h00;
  end

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      flag_ff  <= 5'h00;
      match_ff <= 1'b0;
    end
    else
    begin
      flag_ff  <= (flag_ff & ~flag_clr) | flag_set;
      match_ff <= match;
    end
  end

  // ****************************************************************
  // interrupt lines and debug pulse
  // ****************************************************************
  assign CAPT_IRQ_OUT  = flag_ff[msmt_pkg::FLG_CAPT_BIT] &
                         mask_ff[msmt_pkg::MSK_CAPT_BIT]; // R14
  assign PRESC_IRQ_OUT = (flag_ff[msmt_pkg::FLG_UP_BIT] |
                          flag_ff[msmt_pkg::FLG_DOWN_BIT]) &
                         mask_ff[msmt_pkg::MSK_PCHG_BIT];
  // software tells the two causes apart by the flags
  assign HALT_IRQ_OUT  = (flag_ff[msmt_pkg::FLG_SPD_BIT] &
                          mask_ff[msmt_pkg::MSK_SPD_BIT]) |
                         flag_ff[msmt_pkg::FLG_EMG_BIT]; // R13

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      dbg_ff <= 1'b0;
    else
      dbg_ff <= capt_acc & ctrl_ff[msmt_pkg::CTRL_DBG_BIT]; // R17
  end
  assign DBG_CAPT_OUT = dbg_ff;

  // ****************************************************************
  // read data, sampled in the setup phase
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      rdata_ff <= 32'h0000_0000;
    else if (setup_rd)
    begin
      rdata_ff <= 32'h0000_0000;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CNT_HI))
        rdata_ff[7:0] <= cnt_ff[15:8]; // R18
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CNT_LO))
        rdata_ff[7:0] <= speed_mode ? cnt_ff[7:0] : 8'h00; // R16
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CAP_HI))
        rdata_ff[7:0] <= cap_hi_ff;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CAP_LO))
        rdata_ff[7:0] <= cap_lo_ff;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_COMM_CMP))
        rdata_ff[7:0] <= comm_cmp_ff;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_SPD_CMP))
        rdata_ff[7:0] <= spd_cmp_ff;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_CTRL))
        rdata_ff[4:0] <= ctrl_ff;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_PRESC))
        rdata_ff[3:0] <= presc_ff;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_FLAGS))
        rdata_ff[4:0] <= flag_ff;
      if (reg_hit(PADDR_IN, msmt_pkg::OFF_MASK))
        rdata_ff[2:0] <= mask_ff;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking chk_cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);

  sequence seq_capture;
    capt_acc;
  endsequence

  sequence seq_hi_read;
    run && sns == msmt_pkg::SNS_ENCODER &&
    ctrl_ff[msmt_pkg::CTRL_ECS_BIT] && !lock_ff &&
    acc_rd && PADDR_IN == msmt_pkg::OFF_CNT_HI;
  endsequence

  capt_clears_a: assert property (seq_capture |=> cnt_ff == 16'h0000) // R21
    else $error("counter not cleared after capture");
  capt_copy_a: assert property (seq_capture |=>
      {cap_hi_ff, cap_lo_ff} == $past(cnt_ff)) // R19
    else $error("capture registers do not hold counter");
  lock_discard_a: assert property (lock_ff && capt_evt && run |=>
      $stable(cap_lo_ff) && $stable(cap_hi_ff)) // R22
    else $error("capture taken while low byte locked");
  manual_capt_a: assert property (seq_hi_read |=>
      cnt_ff == 16'h0000 && flag_ff[msmt_pkg::FLG_CAPT_BIT]) // R2
    else $error("high byte read did not capture");
  presc_up_a: assert property (tick_up && presc_ff != 4'hF |=>
      presc_ff == $past(presc_ff) + 4'h1 && cnt_ff == 16'h7FFF &&
      flag_ff[msmt_pkg::FLG_UP_BIT]) // R5
    else $error("prescaler step up wrong");
  presc_sat_a: assert property (run && presc_ff == 4'hF &&
      cnt_ff == 16'hFFFF && !capt_acc |=>
      cnt_ff == 16'hFFFF && presc_ff == 4'hF) // R8
    else $error("saturated counter moved");
  presc_down_a: assert property (dn_ok |=>
      presc_ff == $past(presc_ff) - 4'h1 &&
      flag_ff[msmt_pkg::FLG_DOWN_BIT]) // R6
    else $error("prescaler step down wrong");
  zero_floor_a: assert property (capt_acc && presc_ff == 4'h0 |=>
      presc_ff == 4'h0) // R7
    else $error("prescaler went below zero");
  spd_err_a: assert property (match && !match_ff |=>
      flag_ff[msmt_pkg::FLG_SPD_BIT] ##0
      (!mask_ff[msmt_pkg::MSK_SPD_BIT] || HALT_IRQ_OUT)) // R13
    else $error("speed error not raised");

endmodule : msmt_timer

/* testbench/msmt_sensor_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// rotor sensor model: tacho pin, encoder clock, time base tick
// ****************************************************************
module msmt_sensor_model
(
  // clock
  input  wire logic clk_in,
  // sensor lines
  output logic      tacho_out,
  output logic      enc_clk_out,
  output logic      rtc_tick_out
);
  // idle levels; encoder clock rests low between bursts
  initial
  begin
    tacho_out    = 1'b0;
    enc_clk_out  = 1'b0;
    rtc_tick_out = 1'b0;
  end
  // one rising tacho edge, held past the synchronisers
  task automatic tacho_edge();
    @(posedge clk_in) tacho_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    tacho_out <= 1'b0;
  endtask : tacho_edge
  // n encoder pulses, slow enough for a two-stage sync
  task automatic enc_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_in) enc_clk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      enc_clk_out <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask : enc_pulses
  // one-cycle time base tick
  task automatic rtc_tick();
    @(posedge clk_in) rtc_tick_out <= 1'b1;
    @(posedge clk_in) rtc_tick_out <= 1'b0;
  endtask : rtc_tick
endmodule : msmt_sensor_model

/* testbench/motor_speed_measurement_timer_tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// speed timer bench
// ****************************************************************
module motor_speed_measurement_timer_tb;
  logic        clk = 1'b0;      // core clock, 40 mhz
  logic        srst = 1'b1;     // sync reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, emerg = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
  logic        pready, pslverr, serr, tacho, enc, rtc, cirq, pirq, hirq, dbg;
  int          err_total = 0, checked = 0, dbg_n = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (dbg === 1'b1) dbg_n++;
  msmt_timer msmt_timer_i (.CORE_CLK_IN(clk), .SRST_IN(srst),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TACHO_IN(tacho),
    .ENC_CLK_IN(enc), .EMERG_HALT_IN(emerg), .RTC_TICK_IN(rtc),
    .CAPT_IRQ_OUT(cirq), .PRESC_IRQ_OUT(pirq), .HALT_IRQ_OUT(hirq),
    .DBG_CAPT_OUT(dbg));
  msmt_sensor_model msmt_sensor_model_i (.clk_in(clk),
    .tacho_out(tacho), .enc_clk_out(enc), .rtc_tick_out(rtc));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string w, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, d);
    int n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
    rdata = prdata;
    serr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready", pready, 1'b1);
  endtask : apb
  task automatic rc(input string w, input logic [7:0] a, e);
    apb(1'b0, a, 8'h00);
    check(w, rdata, e);
  endtask : rc
  // set up with the clock off, clear flags, then start
  task automatic setup(input logic [7:0] ctl, hi, lo, ps, msk);
    apb(1'b1, msmt_pkg::OFF_CTRL, ctl & 8'hFE);
    apb(1'b1, msmt_pkg::OFF_CNT_HI, hi);
    apb(1'b1, msmt_pkg::OFF_CNT_LO, lo);
    apb(1'b1, msmt_pkg::OFF_PRESC, ps);
    apb(1'b1, msmt_pkg::OFF_FLAGS, 8'h1F);
    apb(1'b1, msmt_pkg::OFF_MASK, msk);
    apb(1'b1, msmt_pkg::OFF_CTRL, ctl);
  endtask : setup
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // watchdog: whole run is about 1500 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) rc("reset", 8'(i * 4), 8'h00);
    rc("unmapped", 8'h28, 8'h00);
    check("slverr", serr, 1'b1);
    $display("test reset done");
    // tacho capture at field 2 steps the prescaler down
    setup(8'h13, 8'h00, 8'h00, 8'h02, 8'h07);
    repeat (100) @(posedge clk);
    msmt_sensor_model_i.tacho_edge();
    repeat (6) @(posedge clk);
    check("capt irq", cirq, 1'b1);
    check("down irq", pirq, 1'b1);
    check("dbg", 32'(dbg_n), 32'h0000_0001);
    rc("flags", msmt_pkg::OFF_FLAGS, 8'h05);
    rc("presc", msmt_pkg::OFF_PRESC, 8'h01);
    rc("cap hi", msmt_pkg::OFF_CAP_HI, 8'h00);
    apb(1'b0, msmt_pkg::OFF_CAP_LO, 8'h00);
    check("rate", rdata[7:0] inside {[8'h09:8'h0B]}, 1'b1);
    // field 0: no step down; capture masked off
    setup(8'h13, 8'h00, 8'h00, 8'h00, 8'h06);
    msmt_sensor_model_i.tacho_edge();
    repeat (6) @(posedge clk);
    check("masked", cirq, 1'b0);
    rc("flags", msmt_pkg::OFF_FLAGS, 8'h01);
    $display("test tacho done");
    // speed error at compare 00 means count 00FF
    setup(8'h03, 8'h00, 8'h00, 8'h00, 8'h04);
    repeat (550) @(posedge clk);
    check("early", hirq, 1'b0);
    repeat (150) @(posedge clk);
    check("spd err", hirq, 1'b1);
    apb(1'b1, msmt_pkg::OFF_MASK, 8'h00);
    @(posedge clk);
    check("spd mask", hirq, 1'b0);
    emerg <= 1'b1;
    repeat (5) @(posedge clk);
    check("halt", hirq, 1'b1);
    emerg <= 1'b0;
    rc("flags", msmt_pkg::OFF_FLAGS, 8'h18);
    $display("test speed error done");
    // count passes FFFF: field up, count halved
    setup(8'h03, 8'hFF, 8'hF0, 8'h00, 8'h02);
    repeat (55) @(posedge clk);
    check("up irq", pirq, 1'b1);
    rc("presc", msmt_pkg::OFF_PRESC, 8'h01);
    apb(1'b0, msmt_pkg::OFF_CNT_HI, 8'h00);
    check("shift", rdata[7:0] inside {8'h7F, 8'h80}, 1'b1);
    // field 15 at FFFF holds; writes refused while running
    setup(8'h03, 8'hFF, 8'hFF, 8'h0F, 8'h03);
    repeat (100) @(posedge clk);
    apb(1'b1, msmt_pkg::OFF_CNT_HI, 8'h12);
    rc("hold hi", msmt_pkg::OFF_CNT_HI, 8'hFF);
    rc("hold lo", msmt_pkg::OFF_CNT_LO, 8'hFF);
    rc("flags", msmt_pkg::OFF_FLAGS, 8'h00);
    msmt_sensor_model_i.tacho_edge();
    repeat (6) @(posedge clk);
    rc("max hi", msmt_pkg::OFF_CAP_HI, 8'hFF);
    rc("max lo", msmt_pkg::OFF_CAP_LO, 8'hFF);
    $display("test prescaler done");
    // encoder, manual capture by high byte read
    setup(8'h0F, 8'h00, 8'h00, 8'h00, 8'h01);
    msmt_sensor_model_i.enc_pulses(10);
    repeat (4) @(posedge clk);
    rc("pre", msmt_pkg::OFF_CNT_HI, 8'h00);
    rc("man hi", msmt_pkg::OFF_CAP_HI, 8'h00);
    rc("man lo", msmt_pkg::OFF_CAP_LO, 8'h0A);
    rc("cleared", msmt_pkg::OFF_CNT_LO, 8'h00);
    // automatic capture on tick; second one lost while locked
    apb(1'b1, msmt_pkg::OFF_CTRL, 8'h07);
    msmt_sensor_model_i.enc_pulses(5);
    msmt_sensor_model_i.rtc_tick();
    repeat (6) @(posedge clk);
    rc("auto hi", msmt_pkg::OFF_CAP_HI, 8'h00);
    msmt_sensor_model_i.enc_pulses(3);
    msmt_sensor_model_i.rtc_tick();
    repeat (6) @(posedge clk);
    rc("auto lo", msmt_pkg::OFF_CAP_LO, 8'h05);
    apb(1'b1, msmt_pkg::OFF_CTRL, 8'h00);
    rc("pos lo", msmt_pkg::OFF_CNT_LO, 8'h00);
    // hall: both pin edges capture, two more debug pulses
    setup(8'h15, 8'h00, 8'h00, 8'h00, 8'h00);
    msmt_sensor_model_i.tacho_edge();
    repeat (6) @(posedge clk);
    check("hall", 32'(dbg_n), 32'h0000_0004);
    $display("test encoder and hall done");
    print_verdict();
  end
endmodule : motor_speed_measurement_timer_tb
